//--- vcom_regs_defs.svh
// constants for the common-electrode dac and fault-mask register block
`ifndef VCOM_REGS_DEFS_SVH
`define VCOM_REGS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_DAC_CODE 8'h06
`define OFS_MASK_RAILS 8'h08
`define OFS_MASK_COMMON 8'h09

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_DAC_CODE 8'h7f
`define RST_MASK_RAILS 7'h00
`define RST_MASK_COMMON 2'h0

// ----------------------------------------
// field positions, rail mask register
// ----------------------------------------
`define BIT_GATE_OFF_UNDER 6
`define BIT_GATE_OFF_OVER 5
`define BIT_GATE_ON_UNDER 4
`define BIT_GATE_ON_OVER 3
`define BIT_SOURCE_OVERCURRENT 2
`define BIT_BOOST_IN_UNDER 1
`define BIT_BOOST_IN_OVER 0

// ----------------------------------------
// field positions, common-electrode mask register
// ----------------------------------------
`define BIT_COMMON_UNDER 4
`define BIT_COMMON_OVER 3

// ----------------------------------------
// dac step
// ----------------------------------------
`define DAC_STEP_MV 13'd20

`endif

//--- vcom_regs_pkg.sv
// types shared by the common-electrode dac and fault-mask register block
package vcom_regs_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] rail_vec_t;
    typedef logic [1:0] common_vec_t;
    typedef logic [12:0] millivolt_t;

    // whole state of the register block
    typedef struct packed {
        byte_t dac;
        rail_vec_t mask_rails;
        common_vec_t mask_common;
        logic fault_n;
        millivolt_t mv;
        byte_t rdata;
        logic ack;
        logic err;
    } regs_s;

endpackage

//--- fault_gate_if.sv
// faults, suppress masks and combined result between register bank and gate
interface fault_gate_if;
    import vcom_regs_pkg::*;

    rail_vec_t rail_fault;
    rail_vec_t rail_mask;
    common_vec_t common_fault;
    common_vec_t common_mask;
    logic fault_any;

    modport gate (
        input rail_fault,
        input rail_mask,
        input common_fault,
        input common_mask,
        output fault_any
    );

    modport owner (
        output rail_fault,
        output rail_mask,
        output common_fault,
        output common_mask,
        input fault_any
    );
endinterface

//--- fault_gate.sv
// combines rail and common-electrode faults through their suppress masks
module fault_gate (
    fault_gate_if.gate fg
);
    import vcom_regs_pkg::*;

    // a set suppress bit removes the fault at the same position
    function automatic logic unmasked(input logic [6:0] fault, input logic [6:0] suppress);
        unmasked = |(fault & ~suppress);
    endfunction

    // ----------------------------------------
    // combine
    // ----------------------------------------
    // bitwise masking
    assign fg.fault_any = unmasked(fg.rail_fault, fg.rail_mask)
        | unmasked({5'h00, fg.common_fault}, {5'h00, fg.common_mask});
endmodule

//--- vcom_dac_and_fault_mask_regs.sv
// common-electrode dac register, fault suppress masks and fault output
`include "vcom_regs_defs.svh"

module vcom_dac_and_fault_mask_regs (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register access port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire vcom_regs_pkg::byte_t reg_addr_in,
    input wire vcom_regs_pkg::byte_t reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_err_out,
    // live fault indications, high while a fault is present
    input wire vcom_regs_pkg::rail_vec_t rail_fault_in,
    input wire vcom_regs_pkg::common_vec_t common_fault_in,
    // dac and fault outputs
    output logic [7:0] dac_code_out,
    output logic [12:0] common_mv_out,
    output logic fault_out_n
);
    import vcom_regs_pkg::*;

    regs_s q;
    regs_s d;
    fault_gate_if fg();

    // ----------------------------------------
    // fault gating
    // ----------------------------------------
    assign fg.rail_fault = rail_fault_in;
    assign fg.rail_mask = q.mask_rails;
    assign fg.common_fault = common_fault_in;
    assign fg.common_mask = q.mask_common;

    fault_gate u_gate (
        .fg(fg.gate)
    );

    function automatic logic mapped(input byte_t addr);
        mapped = (addr == `OFS_DAC_CODE) || (addr == `OFS_MASK_RAILS)
            || (addr == `OFS_MASK_COMMON);
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.ack = reg_wr_in | reg_rd_in;
        d.err = (reg_wr_in | reg_rd_in) & ~mapped(reg_addr_in);
        if (reg_wr_in) begin
            case (reg_addr_in)
                `OFS_DAC_CODE: d.dac = reg_wdata_in;
                `OFS_MASK_RAILS: d.mask_rails = reg_wdata_in[6:0];
                `OFS_MASK_COMMON: d.mask_common = {reg_wdata_in[`BIT_COMMON_UNDER],
                    reg_wdata_in[`BIT_COMMON_OVER]};
                default: d.dac = q.dac;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                `OFS_DAC_CODE: d.rdata = q.dac;
                `OFS_MASK_RAILS: d.rdata = {1'b0, q.mask_rails};
                `OFS_MASK_COMMON: d.rdata = {3'h0, q.mask_common, 3'h0};
                default: d.rdata = 8'h00;
            endcase
        end
        d.mv = 13'(d.dac) * `DAC_STEP_MV;
        // output low only for unmasked faults
        d.fault_n = ~fg.fault_any;
        if (rst_in) begin
            d.dac = `RST_DAC_CODE;
            d.mask_rails = `RST_MASK_RAILS;
            d.mask_common = `RST_MASK_COMMON;
            d.mv = 13'(`RST_DAC_CODE) * `DAC_STEP_MV;
            d.fault_n = 1'b1;
            d.rdata = 8'h00;
            d.ack = 1'b0;
            d.err = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        q <= d;
    end

    // ----------------------------------------
    // outputs, all straight from the state flops
    // ----------------------------------------
    assign reg_rdata_out = q.rdata;
    assign reg_ack_out = q.ack;
    assign reg_err_out = q.err;
    assign dac_code_out = q.dac;
    assign common_mv_out = q.mv;
    assign fault_out_n = q.fault_n;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // only one fault present, nothing else, so the single bit decides
    logic only_rail;
    logic no_common;
    assign no_common = (common_fault_in == 2'h0);
    assign only_rail = no_common && ($countones(rail_fault_in) == 1);

    // write, one idle cycle, then read back, as the host paces its strobes
    property p_dac_write;
        reg_wr_in && reg_addr_in == `OFS_DAC_CODE ##1 !reg_wr_in ##1 reg_rd_in && !reg_wr_in
            && reg_addr_in == `OFS_DAC_CODE |=> reg_rdata_out == $past(reg_wdata_in, 3);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("dac code readback wrong");

    property p_step;
        $changed(dac_code_out) |-> common_mv_out == 13'(dac_code_out) * `DAC_STEP_MV;
    endproperty
    a_step: assert property (p_step) else $error("dac millivolts not 20 per step");

    property p_reset_values;
        $past(rst_in) |-> dac_code_out == 8'h7f && q.mask_rails == 7'h00
            && q.mask_common == 2'h0 && fault_out_n;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_unmasked_fault;
        (|(rail_fault_in & ~q.mask_rails)) |=> !fault_out_n;
    endproperty
    a_unmasked_fault: assert property (p_unmasked_fault) else $error("fault not shown");

    property p_gate_off_under;
        only_rail && rail_fault_in[`BIT_GATE_OFF_UNDER] && q.mask_rails[`BIT_GATE_OFF_UNDER]
            |=> fault_out_n;
    endproperty
    a_gate_off_under: assert property (p_gate_off_under) else $error("bit 6 leak");

    property p_gate_off_over;
        only_rail && rail_fault_in[`BIT_GATE_OFF_OVER] && q.mask_rails[`BIT_GATE_OFF_OVER]
            |=> fault_out_n;
    endproperty
    a_gate_off_over: assert property (p_gate_off_over) else $error("bit 5 leak");

    property p_gate_on_under;
        only_rail && rail_fault_in[`BIT_GATE_ON_UNDER] && q.mask_rails[`BIT_GATE_ON_UNDER]
            |=> fault_out_n;
    endproperty
    a_gate_on_under: assert property (p_gate_on_under) else $error("bit 4 leak");

    property p_source_oc;
        only_rail && rail_fault_in[`BIT_SOURCE_OVERCURRENT]
            && q.mask_rails[`BIT_SOURCE_OVERCURRENT] |=> fault_out_n;
    endproperty
    a_source_oc: assert property (p_source_oc) else $error("bit 2 leak");

    property p_boost_under;
        only_rail && rail_fault_in[`BIT_BOOST_IN_UNDER] && q.mask_rails[`BIT_BOOST_IN_UNDER]
            |=> fault_out_n;
    endproperty
    a_boost_under: assert property (p_boost_under) else $error("bit 1 leak");

    property p_common_under;
        rail_fault_in == 7'h00 && common_fault_in == 2'h2 && q.mask_common[1] |=> fault_out_n;
    endproperty
    a_common_under: assert property (p_common_under) else $error("common under leak");

    property p_common_over;
        rail_fault_in == 7'h00 && common_fault_in == 2'h1 && !q.mask_common[0]
            |=> !fault_out_n;
    endproperty
    a_common_over: assert property (p_common_over) else $error("common over lost");

    property p_common_over_masked;
        rail_fault_in == 7'h00 && common_fault_in == 2'h1 && q.mask_common[0] |=> fault_out_n;
    endproperty
    a_common_over_masked: assert property (p_common_over_masked)
        else $error("common over leak");

    property p_other_bits;
        only_rail && (|(rail_fault_in & q.mask_rails & 7'h09)) |=> fault_out_n;
    endproperty
    a_other_bits: assert property (p_other_bits) else $error("bit 3 or 0 leak");

    property p_reserved_read;
        reg_rd_in && reg_addr_in == `OFS_MASK_COMMON
            |=> (reg_rdata_out & 8'he7) == 8'h00 && reg_ack_out;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bit set");

    // an unmapped write must leave every stored value alone
    property p_unmapped_write;
        reg_wr_in && !mapped(reg_addr_in) |=> $stable(dac_code_out) && $stable(q.mask_rails)
            && $stable(q.mask_common);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("stray write");

    property p_ack_err;
        (reg_wr_in || reg_rd_in) |=> reg_ack_out && reg_err_out == !mapped($past(reg_addr_in));
    endproperty
    a_ack_err: assert property (p_ack_err) else $error("access unanswered");

    c_dac_write: cover property (reg_wr_in && reg_addr_in == `OFS_DAC_CODE ##1 reg_ack_out);
    c_fault_low: cover property (!fault_out_n ##1 fault_out_n);
    c_suppressed: cover property (|(rail_fault_in & q.mask_rails) ##1 fault_out_n);
    c_unmapped: cover property (reg_err_out);
endmodule

//--- reg_host.sv
// host model driving the block's register strobe port
module reg_host
    import vcom_regs_pkg::*;
(
    // clock
    input wire logic clk_in,
    // answers from the block
    input wire logic [7:0] rdata_in,
    input wire logic ack_in,
    input wire logic err_in,
    // requests to the block
    output logic wr_out,
    output logic rd_out,
    output byte_t addr_out,
    output byte_t wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // one-cycle strobe; the answer is registered on the taking edge and read half a cycle later
    task automatic xfer(input logic w, input byte_t a, input byte_t d,
                        output byte_t q, output logic ok, output logic e);
        @(negedge clk_in);
        wr_out <= w;
        rd_out <= !w;
        addr_out <= a;
        wdata_out <= d;
        @(negedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        // released lines carry junk so stale values are never trusted
        addr_out <= ~a;
        wdata_out <= ~d;
        q = rdata_in;
        ok = ack_in;
        e = err_in;
    endtask
endmodule

//--- test_vcom_dac_and_fault_mask_regs.sv
// self-checking bench for the dac and fault-mask register block
`include "vcom_regs_defs.svh"
module test_vcom_dac_and_fault_mask_regs import vcom_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr, rd, ack, err, fault_n;
    byte_t addr, wdata;
    logic [7:0] rdata, dac_code;
    logic [12:0] mv;
    rail_vec_t rail_fault = '0;
    common_vec_t common_fault = '0;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    byte_t junk;
    byte_t last_code;

    always #10 clk_in = ~clk_in;

    vcom_dac_and_fault_mask_regs u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err),
        .rail_fault_in(rail_fault), .common_fault_in(common_fault),
        .dac_code_out(dac_code), .common_mv_out(mv), .fault_out_n(fault_n));

    reg_host u_host (.clk_in(clk_in), .rdata_in(rdata), .ack_in(ack), .err_in(err),
        .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every access answers; only unmapped addresses flag an error
    task automatic reg_io(input logic w, input byte_t a, input byte_t d, output byte_t q);
        logic ok, e, unmapped;
        unmapped = a != `OFS_DAC_CODE && a != `OFS_MASK_RAILS && a != `OFS_MASK_COMMON;
        u_host.xfer(w, a, d, q, ok, e);
        chk(13'(ok), 13'h1);
        chk(13'(e), 13'(unmapped));
    endtask

    task automatic rd_exp(input byte_t a, input byte_t exp);
        byte_t q;
        reg_io(1'b0, a, 8'h00, q);
        chk(13'(q), 13'(exp));
    endtask

    task automatic set_masks(input rail_vec_t rm, input common_vec_t cm);
        byte_t q;
        reg_io(1'b1, `OFS_MASK_RAILS, {1'b0, rm}, q);
        reg_io(1'b1, `OFS_MASK_COMMON, {3'h0, cm, 3'h0}, q);
    endtask

    function automatic logic exp_fault_n(rail_vec_t rf, rail_vec_t rm,
                                         common_vec_t cf, common_vec_t cm);
        return !((|(rf & ~rm)) || (|(cf & ~cm)));
    endfunction

    task automatic try_fault(input rail_vec_t rf, input common_vec_t cf,
                             input rail_vec_t rm, input common_vec_t cm);
        @(negedge clk_in);
        rail_fault <= rf;
        common_fault <= cf;
        @(negedge clk_in);
        chk(13'(fault_n), 13'(exp_fault_n(rf, rm, cf, cm)));
    endtask

    task automatic dac_exp(input byte_t code);
        byte_t q;
        last_code = code;
        reg_io(1'b1, `OFS_DAC_CODE, code, q);
        chk(13'(dac_code), 13'(code));
        chk(mv, 13'(code) * `DAC_STEP_MV);
        rd_exp(`OFS_DAC_CODE, code);
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        rail_vec_t rm, rf;
        common_vec_t cm, cf;
        void'($urandom(92));
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk(13'(dac_code), 13'h7f);
        chk(mv, 13'd2540);
        rd_exp(`OFS_DAC_CODE, 8'h7f);
        rd_exp(`OFS_MASK_RAILS, 8'h00);
        rd_exp(`OFS_MASK_COMMON, 8'h00);
        try_fault(7'h7f, 2'h3, 7'h00, 2'h0);
        dac_exp(8'h00);
        dac_exp(8'hff);
        for (int i = 0; i < 8; i++) begin
            dac_exp(8'($urandom));
        end
        // reserved bits and an unmapped place
        reg_io(1'b1, `OFS_MASK_RAILS, 8'hff, junk);
        rd_exp(`OFS_MASK_RAILS, 8'h7f);
        reg_io(1'b1, `OFS_MASK_COMMON, 8'hff, junk);
        rd_exp(`OFS_MASK_COMMON, 8'h18);
        reg_io(1'b1, 8'h07, 8'h00, junk);
        rd_exp(8'h07, 8'h00);
        // the unmapped write must not have touched the dac code
        chk(13'(dac_code), 13'(last_code));
        // each suppress bit alone, against its own fault and all others
        for (int i = 0; i < 9; i++) begin
            rm = (i < 7) ? 7'(1 << i) : 7'h00;
            cm = (i >= 7) ? 2'(1 << (i - 7)) : 2'h0;
            set_masks(7'h00, 2'h0);
            try_fault(rm, cm, 7'h00, 2'h0);
            set_masks(rm, cm);
            try_fault(rm, cm, rm, cm);
            try_fault(7'h7f, 2'h3, rm, cm);
        end
        for (int i = 0; i < 20; i++) begin
            rm = 7'($urandom);
            cm = 2'($urandom);
            rf = 7'($urandom) & (rm | 7'($urandom));
            cf = 2'($urandom) & (cm | 2'($urandom));
            set_masks(rm, cm);
            try_fault(rf, cf, rm, cm);
        end
        // mid-run reset must bring back the power-up values
        @(negedge clk_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        chk(13'(dac_code), 13'h7f);
        chk(mv, 13'd2540);
        rd_exp(`OFS_MASK_RAILS, 8'h00);
        rd_exp(`OFS_MASK_COMMON, 8'h00);
        try_fault(7'h7f, 2'h3, 7'h00, 2'h0);
        close_out();
    end
endmodule
